// ==== core/ddrpc_pkg.sv ====
// Purpose: shared constants and types for the ddr2 pin and command link
// Assumes: 40 MHz core clock, link clock made by the controller end
// Notes: command enum ordinals are also the controller op codes
// Functional notes
// - activate samples row on all address lines
// - column from low ten bits, bit ten autoprecharge
// - top address line is part of row
// - chip select high masks every command
// - command pins latched at link clock rise
// - select, ras low: activate opens the bank
// - select, ras, we low: precharge idles bank
// - select, cas low: read or write by we
// - strobe edge aligned on reads, centred writes
// - extended option turns mask into read strobe
// - extended bit selects differential strobe pairs
// - mask high discards that write beat
// - eight-bit two-way data bus
// - termination input enables on-die termination
// - termination input ignored when disabled
// - bank lines select the command's bank
package ddrpc_pkg;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int BA_W = 3;
  localparam int DQ_W = 8;
  localparam int NBANK = 8;
  localparam int BURST = 4;
  localparam int MEM_IDX_W = 6;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CK_PERIOD_NS = 200;
  localparam int CK_HALF = CK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int CK_MID = CK_HALF / 2;
  localparam int AUTO_PRE_BIT = 10;
  localparam int EMR_RDQS_BIT = 11;
  localparam int EMR_DQSN_OFF_BIT = 10;
  localparam int EMR_RTT_BIT0 = 2;
  localparam int EMR_RTT_BIT1 = 6;
  localparam logic [2:0] EMR1_BANK = 3'h1;
  localparam logic EMR_RDQS_RST = 1'b0;
  localparam logic EMR_DIFF_RST = 1'b1;
  localparam logic EMR_RTT_RST = 1'b0;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_BA_LSB = 16;
  localparam int CMD_OP_LSB = 24;
  localparam int WDATA_MASK_BIT = 8;
  localparam int CTRL_ODT_BIT = 0;
  localparam int CTRL_DIFF_BIT = 1;
  localparam int CTRL_DM_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_MRS, CMD_DESEL, CMD_OTHER
  } ddrpc_cmd_t;

  // pins order {csN, rasN, casN, weN}
  function automatic ddrpc_cmd_t ddrpc_decode(input logic [3:0] p);
    ddrpc_cmd_t c;
    c = CMD_OTHER;
    if (p[3]) begin
      c = CMD_DESEL;
    end else begin
      unique case (p[2:0])
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h2: c = CMD_PRE;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        3'h0: c = CMD_MRS;
        default: c = CMD_OTHER;
      endcase
    end
    return c;
  endfunction

  function automatic logic [3:0] ddrpc_encode(input ddrpc_cmd_t c);
    logic [3:0] p;
    p = 4'hF;
    unique case (c)
      CMD_NOP: p = 4'h7;
      CMD_ACT: p = 4'h3;
      CMD_PRE: p = 4'h2;
      CMD_RD: p = 4'h5;
      CMD_WR: p = 4'h4;
      CMD_MRS: p = 4'h0;
      default: p = 4'hF;
    endcase
    return p;
  endfunction
endpackage

// ==== core/ddrpc_if.sv ====
// Purpose: pins between controller end and memory end
// Assumes: output enables active low
// Notes: two-way pins resolved here, undriven reads as zero
`timescale 1ns/1ps
interface ddrpc_if;
  logic ck;
  logic ckN;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic odt;
  logic [ddrpc_pkg::BA_W-1:0] ba;
  logic [ddrpc_pkg::ROW_W-1:0] addr;
  logic [ddrpc_pkg::DQ_W-1:0] dqH;
  logic [ddrpc_pkg::DQ_W-1:0] dqD;
  logic dqHOeN;
  logic dqDOeN;
  logic dqsH;
  logic dqsHOeN;
  logic dqsNH;
  logic dqsNHOeN;
  logic dmH;
  logic dmHOeN;
  logic dqsD;
  logic dqsDOeN;
  logic dqsND;
  logic dqsNDOeN;
  logic rdqsD;
  logic rdqsDOeN;
  logic rdqsND;
  logic rdqsNDOeN;
  logic [ddrpc_pkg::DQ_W-1:0] dq;
  logic dqs;
  logic dqsN;
  logic dm;
  logic rdqsN;

  assign dq = !dqDOeN ? dqD : (!dqHOeN ? dqH : '0);
  assign dqs = !dqsDOeN ? dqsD : (!dqsHOeN ? dqsH : 1'b0);
  assign dqsN = !dqsNDOeN ? dqsND : (!dqsNHOeN ? dqsNH : 1'b0);
  assign dm = !rdqsDOeN ? rdqsD : (!dmHOeN ? dmH : 1'b0);
  assign rdqsN = !rdqsNDOeN ? rdqsND : 1'b0;

  modport host (
    output ck, ckN, csN, rasN, casN, weN, odt, ba, addr,
    output dqH, dqHOeN, dqsH, dqsHOeN, dqsNH, dqsNHOeN, dmH, dmHOeN,
    input dq, dqs
  );
  modport device (
    input ck, csN, rasN, casN, weN, odt, ba, addr, dq, dqs, dm,
    output dqD, dqDOeN, dqsD, dqsDOeN, dqsND, dqsNDOeN, rdqsD, rdqsDOeN, rdqsND, rdqsNDOeN
  );
endinterface

// ==== core/ddrpc_fifo.sv ====
// Purpose: write-data buffer with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: ready low when full, valid low when empty
`timescale 1ns/1ps
module ddrpc_fifo #(
  parameter int WIDTH = ddrpc_pkg::FIFO_W,
  parameter int DEPTH = ddrpc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
  } ddrpc_fifo_t;
  ddrpc_fifo_t s_q;
  ddrpc_fifo_t s_d;
  logic push;
  logic pop;

  assign inReady = s_q.count != (PW+1)'(DEPTH);
  assign outValid = s_q.count != '0;
  assign outData = s_q.mem[s_q.rp];

  always_comb begin
    s_d = s_q;
    push = inValid & inReady;
    pop = outReady & outValid;
    if (push) begin
      s_d.mem[s_q.wp] = inData;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.count = s_q.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end
endmodule

// ==== core/ddrpc_ctrl.sv ====
// Purpose: controller end, takes orders over ahb-lite and drives the link
// Assumes: single whole-word transfers, one slave
// Notes: link clock made here by dividing the core clock
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module ddrpc_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  ddrpc_if.host pins
);
  typedef enum logic [2:0] {CS_IDLE, CS_CMD, CS_WR, CS_RD} ddrpc_cstate_t;
  typedef struct packed {
    ddrpc_cstate_t st;
    logic [2:0] cnt;
    logic ck;
    logic [3:0] cmdPins;
    logic [ddrpc_pkg::BA_W-1:0] ba;
    logic [ddrpc_pkg::ROW_W-1:0] addr;
    logic [ddrpc_pkg::DQ_W-1:0] dq;
    logic dqOeN;
    logic dqs;
    logic dqsN;
    logic dqsOeN;
    logic dqsNOeN;
    logic dm;
    logic dmOeN;
    logic [ddrpc_pkg::DQ_W:0] sy1;
    logic [ddrpc_pkg::DQ_W:0] sy2;
    logic dqs3;
    logic pend;
    ddrpc_pkg::ddrpc_cmd_t op;
    logic [ddrpc_pkg::BA_W-1:0] pBa;
    logic [ddrpc_pkg::ROW_W-1:0] pAddr;
    logic [2:0] beat;
    logic [31:0] rdata;
    logic rdValid;
    logic [2:0] ctrl;
    logic aWr;
    logic [7:0] aAddr;
    logic ready;
    logic [31:0] rd;
  } ddrpc_ctrl_t;
  ddrpc_ctrl_t s_q;
  ddrpc_ctrl_t s_d;
  logic tick;
  logic mid;
  logic present;
  logic fInValid;
  logic fInReady;
  logic fOutValid;
  logic fOutReady;
  logic [ddrpc_pkg::FIFO_W-1:0] fOut;
  logic busy;

  ddrpc_fifo #(.WIDTH(ddrpc_pkg::FIFO_W), .DEPTH(ddrpc_pkg::FIFO_DEPTH)) i_ddrpc_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .inValid(fInValid),
    .inReady(fInReady),
    .inData(hwdata[ddrpc_pkg::FIFO_W-1:0]),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOut)
  );

  always_comb begin
    s_d = s_q;
    busy = s_q.pend | (s_q.st != CS_IDLE);
    tick = s_q.cnt == 3'(ddrpc_pkg::CK_HALF - 1);
    mid = s_q.cnt == 3'(ddrpc_pkg::CK_MID - 1);
    present = 1'b0;
    fInValid = 1'b0;
    s_d.cnt = tick ? 3'h0 : s_q.cnt + 3'h1;
    if (tick) begin
      s_d.ck = ~s_q.ck;
    end
    s_d.sy1 = {pins.dqs, pins.dq};
    s_d.sy2 = s_q.sy1;
    s_d.dqs3 = s_q.sy2[ddrpc_pkg::DQ_W];
    // ahb address phase
    if (hsel && htrans[1] && hready) begin
      s_d.aAddr = haddr[7:0];
      s_d.aWr = hwrite;
      s_d.ready = !hwrite;
      unique case (haddr[7:0])
        ddrpc_pkg::REG_STAT: s_d.rd = {28'h0, ~fOutValid, ~fInReady, s_q.rdValid, busy};
        ddrpc_pkg::REG_RDATA: s_d.rd = s_q.rdata;
        ddrpc_pkg::REG_CTRL: s_d.rd = {29'h0, s_q.ctrl};
        default: s_d.rd = 32'h0;
      endcase
      if (!hwrite && haddr[7:0] == ddrpc_pkg::REG_RDATA) begin
        s_d.rdValid = 1'b0;
      end
    end
    // ahb write data phase, stalls until accepted
    if (s_q.aWr && !s_q.ready) begin
      s_d.ready = 1'b1;
      s_d.aWr = 1'b0;
      unique case (s_q.aAddr)
        ddrpc_pkg::REG_CMD: begin
          if (busy) begin
            s_d.ready = 1'b0;
            s_d.aWr = 1'b1;
          end else begin
            s_d.pend = 1'b1;
            s_d.op = ddrpc_pkg::ddrpc_cmd_t'(hwdata[ddrpc_pkg::CMD_OP_LSB +: 3]);
            s_d.pBa = hwdata[ddrpc_pkg::CMD_BA_LSB +: ddrpc_pkg::BA_W];
            s_d.pAddr = hwdata[ddrpc_pkg::CMD_ADDR_LSB +: ddrpc_pkg::ROW_W];
          end
        end
        ddrpc_pkg::REG_WDATA: begin
          fInValid = 1'b1;
          if (!fInReady) begin
            s_d.ready = 1'b0;
            s_d.aWr = 1'b1;
          end
        end
        ddrpc_pkg::REG_CTRL: s_d.ctrl = hwdata[2:0];
        default: ;
      endcase
    end
    // link sequencing; command pins change on link clock fall, write data on both edges
    unique case (s_q.st)
      CS_IDLE: begin
        if (s_q.pend && tick && s_q.ck) begin
          s_d.pend = 1'b0;
          s_d.cmdPins = ddrpc_pkg::ddrpc_encode(s_q.op);
          s_d.ba = s_q.pBa;
          s_d.addr = s_q.pAddr;
          s_d.st = CS_CMD;
        end
      end
      CS_CMD: begin
        if (tick && s_q.ck) begin
          s_d.cmdPins = 4'hF;
          s_d.st = CS_IDLE;
          s_d.beat = 3'h0;
          if (s_q.op == ddrpc_pkg::CMD_WR) begin
            s_d.st = CS_WR;
            s_d.dqOeN = 1'b0;
            s_d.dqs = 1'b0;
            s_d.dqsN = 1'b1;
            s_d.dqsOeN = 1'b0;
            s_d.dqsNOeN = ~s_q.ctrl[ddrpc_pkg::CTRL_DIFF_BIT];
            s_d.dmOeN = ~s_q.ctrl[ddrpc_pkg::CTRL_DM_BIT];
            present = 1'b1;
          end else if (s_q.op == ddrpc_pkg::CMD_RD) begin
            s_d.st = CS_RD;
          end
        end
      end
      CS_WR: begin
        if (mid) begin
          s_d.dqs = ~s_q.dqs;
          s_d.dqsN = ~s_q.dqsN;
          s_d.beat = s_q.beat + 3'h1;
        end
        if (tick) begin
          if (s_q.beat == 3'(ddrpc_pkg::BURST)) begin
            s_d.dqOeN = 1'b1;
            s_d.dqsOeN = 1'b1;
            s_d.dqsNOeN = 1'b1;
            s_d.dmOeN = 1'b1;
            s_d.st = CS_IDLE;
          end else begin
            present = 1'b1;
          end
        end
      end
      CS_RD: begin
        if (s_q.sy2[ddrpc_pkg::DQ_W] != s_q.dqs3) begin
          s_d.rdata = {s_q.sy2[ddrpc_pkg::DQ_W-1:0], s_q.rdata[31:8]};
          s_d.beat = s_q.beat + 3'h1;
          if (s_q.beat == 3'(ddrpc_pkg::BURST - 1)) begin
            s_d.rdValid = 1'b1;
            s_d.st = CS_IDLE;
          end
        end
      end
      default: s_d.st = CS_IDLE;
    endcase
    fOutReady = present;
    if (present) begin
      s_d.dq = fOut[ddrpc_pkg::DQ_W-1:0];
      s_d.dm = fOutValid ? fOut[ddrpc_pkg::WDATA_MASK_BIT] : 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.cmdPins <= 4'hF;
      s_q.dqOeN <= 1'b1;
      s_q.dqsOeN <= 1'b1;
      s_q.dqsNOeN <= 1'b1;
      s_q.dmOeN <= 1'b1;
      s_q.ready <= 1'b1;
      s_q.ctrl <= ddrpc_pkg::CTRL_RST;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rd;
  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign pins.ck = s_q.ck;
  assign pins.ckN = ~s_q.ck;
  assign {pins.csN, pins.rasN, pins.casN, pins.weN} = s_q.cmdPins;
  assign pins.ba = s_q.ba;
  assign pins.addr = s_q.addr;
  assign pins.odt = s_q.ctrl[ddrpc_pkg::CTRL_ODT_BIT];
  assign pins.dqH = s_q.dq;
  assign pins.dqHOeN = s_q.dqOeN;
  assign pins.dqsH = s_q.dqs;
  assign pins.dqsHOeN = s_q.dqsOeN;
  assign pins.dqsNH = s_q.dqsN;
  assign pins.dqsNHOeN = s_q.dqsNOeN;
  assign pins.dmH = s_q.dm;
  assign pins.dmHOeN = s_q.dmOeN;
endmodule

// ==== core/ddrpc_device.sv ====
// Purpose: memory end, decodes command pins and moves burst data
// Assumes: all pins sampled through two flip-flops on clk
// Notes: small store indexed by bank, row bit 0 and column
`timescale 1ns/1ps
module ddrpc_device (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  ddrpc_if.device pins,
  output logic [ddrpc_pkg::NBANK-1:0] bankOpen,
  output ddrpc_pkg::ddrpc_cmd_t lastCmd,
  output logic cmdPulse,
  output logic termOn,
  output logic rdqsOn,
  output logic diffOn
);
  typedef struct packed {
    logic ck;
    logic [3:0] cmd;
    logic [ddrpc_pkg::BA_W-1:0] ba;
    logic [ddrpc_pkg::ROW_W-1:0] addr;
    logic odt;
    logic dqs;
    logic dm;
    logic [ddrpc_pkg::DQ_W-1:0] dq;
  } ddrpc_dpin_t;
  typedef enum logic [1:0] {DS_IDLE, DS_WR, DS_RDPRE, DS_RD} ddrpc_dstate_t;
  typedef struct packed {
    ddrpc_dpin_t p1;
    ddrpc_dpin_t p2;
    logic ck3;
    logic dqs3;
    ddrpc_dstate_t st;
    logic [ddrpc_pkg::NBANK-1:0] open;
    logic [ddrpc_pkg::NBANK-1:0][ddrpc_pkg::ROW_W-1:0] row;
    logic [ddrpc_pkg::BA_W-1:0] curBa;
    logic [ddrpc_pkg::COL_W-1:0] col;
    logic autoPre;
    logic [2:0] beat;
    logic [(1 << ddrpc_pkg::MEM_IDX_W)-1:0][ddrpc_pkg::DQ_W-1:0] mem;
    logic rdqsEn;
    logic diffEn;
    logic rttEn;
    logic term;
    ddrpc_pkg::ddrpc_cmd_t last;
    logic pulse;
    logic [ddrpc_pkg::DQ_W-1:0] dq;
    logic dqOeN;
    logic dqs;
    logic dqsN;
    logic dqsOeN;
    logic dqsNOeN;
    logic rdqsOeN;
    logic rdqsNOeN;
  } ddrpc_dev_t;
  ddrpc_dev_t s_q;
  ddrpc_dev_t s_d;
  ddrpc_dpin_t pinNow;
  ddrpc_pkg::ddrpc_cmd_t cmd;
  logic ckRise;
  logic ckEdge;
  logic dqsEdge;
  logic [ddrpc_pkg::MEM_IDX_W-1:0] idx;

  function automatic logic [ddrpc_pkg::MEM_IDX_W-1:0] memIndex(
    input logic [ddrpc_pkg::BA_W-1:0] ba,
    input logic rowBit,
    input logic [1:0] col,
    input logic [2:0] beat
  );
    logic [1:0] c;
    c = col + beat[1:0];
    return {ba, rowBit, c};
  endfunction

  assign pinNow = '{ck: pins.ck, cmd: {pins.csN, pins.rasN, pins.casN, pins.weN},
    ba: pins.ba, addr: pins.addr, odt: pins.odt, dqs: pins.dqs, dm: pins.dm, dq: pins.dq};

  always_comb begin
    s_d = s_q;
    s_d.p1 = pinNow;
    s_d.p2 = s_q.p1;
    s_d.ck3 = s_q.p2.ck;
    s_d.dqs3 = s_q.p2.dqs;
    s_d.pulse = 1'b0;
    ckRise = s_q.p2.ck & ~s_q.ck3;
    ckEdge = s_q.p2.ck ^ s_q.ck3;
    dqsEdge = s_q.p2.dqs ^ s_q.dqs3;
    cmd = ddrpc_pkg::ddrpc_decode(s_q.p2.cmd);
    idx = memIndex(s_q.curBa, s_q.row[s_q.curBa][0], s_q.col[1:0], s_q.beat);
    s_d.term = s_q.p2.odt & s_q.rttEn;
    if (ckRise && cmd != ddrpc_pkg::CMD_DESEL) begin
      s_d.pulse = 1'b1;
      s_d.last = cmd;
      unique case (cmd)
        ddrpc_pkg::CMD_ACT: begin
          s_d.open[s_q.p2.ba] = 1'b1;
          s_d.row[s_q.p2.ba] = s_q.p2.addr;
        end
        ddrpc_pkg::CMD_PRE: begin
          if (s_q.p2.addr[ddrpc_pkg::AUTO_PRE_BIT]) begin
            s_d.open = '0;
          end else begin
            s_d.open[s_q.p2.ba] = 1'b0;
          end
        end
        ddrpc_pkg::CMD_RD, ddrpc_pkg::CMD_WR: begin
          if (s_q.st == DS_IDLE && s_q.open[s_q.p2.ba]) begin
            s_d.curBa = s_q.p2.ba;
            s_d.col = s_q.p2.addr[ddrpc_pkg::COL_W-1:0];
            s_d.autoPre = s_q.p2.addr[ddrpc_pkg::AUTO_PRE_BIT];
            s_d.beat = 3'h0;
            s_d.st = (cmd == ddrpc_pkg::CMD_WR) ? DS_WR : DS_RDPRE;
          end
        end
        ddrpc_pkg::CMD_MRS: begin
          if (s_q.p2.ba == ddrpc_pkg::EMR1_BANK) begin
            s_d.rdqsEn = s_q.p2.addr[ddrpc_pkg::EMR_RDQS_BIT];
            s_d.diffEn = ~s_q.p2.addr[ddrpc_pkg::EMR_DQSN_OFF_BIT];
            s_d.rttEn = s_q.p2.addr[ddrpc_pkg::EMR_RTT_BIT0] | s_q.p2.addr[ddrpc_pkg::EMR_RTT_BIT1];
          end
        end
        default: ;
      endcase
    end
    unique case (s_q.st)
      DS_IDLE: ;
      DS_WR: begin
        // capture on each strobe edge
        if (dqsEdge) begin
          if (s_q.rdqsEn || !s_q.p2.dm) begin
            s_d.mem[idx] = s_q.p2.dq;
          end
          s_d.beat = s_q.beat + 3'h1;
          if (s_q.beat == 3'(ddrpc_pkg::BURST - 1)) begin
            s_d.st = DS_IDLE;
            if (s_q.autoPre) begin
              s_d.open[s_q.curBa] = 1'b0;
            end
          end
        end
      end
      DS_RDPRE: begin
        if (ckEdge) begin
          s_d.dqOeN = 1'b0;
          s_d.dqs = 1'b0;
          s_d.dqsN = 1'b1;
          s_d.dqsOeN = 1'b0;
          s_d.dqsNOeN = ~s_q.diffEn;
          s_d.rdqsOeN = ~s_q.rdqsEn;
          s_d.rdqsNOeN = ~(s_q.rdqsEn & s_q.diffEn);
          s_d.st = DS_RD;
        end
      end
      DS_RD: begin
        if (ckEdge) begin
          if (s_q.beat == 3'(ddrpc_pkg::BURST)) begin
            s_d.dqOeN = 1'b1;
            s_d.dqsOeN = 1'b1;
            s_d.dqsNOeN = 1'b1;
            s_d.rdqsOeN = 1'b1;
            s_d.rdqsNOeN = 1'b1;
            s_d.st = DS_IDLE;
            if (s_q.autoPre) begin
              s_d.open[s_q.curBa] = 1'b0;
            end
          end else begin
            s_d.dq = s_q.mem[idx];
            s_d.dqs = ~s_q.dqs;
            s_d.dqsN = ~s_q.dqsN;
            s_d.beat = s_q.beat + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.rdqsEn <= ddrpc_pkg::EMR_RDQS_RST;
      s_q.diffEn <= ddrpc_pkg::EMR_DIFF_RST;
      s_q.rttEn <= ddrpc_pkg::EMR_RTT_RST;
      s_q.last <= ddrpc_pkg::CMD_DESEL;
      s_q.dqOeN <= 1'b1;
      s_q.dqsOeN <= 1'b1;
      s_q.dqsNOeN <= 1'b1;
      s_q.rdqsOeN <= 1'b1;
      s_q.rdqsNOeN <= 1'b1;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign bankOpen = s_q.open;
  assign lastCmd = s_q.last;
  assign cmdPulse = s_q.pulse;
  assign termOn = s_q.term;
  assign rdqsOn = s_q.rdqsEn;
  assign diffOn = s_q.diffEn;
  assign pins.dqD = s_q.dq;
  assign pins.dqDOeN = s_q.dqOeN;
  assign pins.dqsD = s_q.dqs;
  assign pins.dqsDOeN = s_q.dqsOeN;
  assign pins.dqsND = s_q.dqsN;
  assign pins.dqsNDOeN = s_q.dqsNOeN;
  assign pins.rdqsD = s_q.dqs;
  assign pins.rdqsDOeN = s_q.rdqsOeN;
  assign pins.rdqsND = s_q.dqsN;
  assign pins.rdqsNDOeN = s_q.rdqsNOeN;
endmodule

// ==== tb/ddrpc_props.sv ====
// Purpose: link pin properties between the two ends
// Assumes: ck made by controller, high for four clk
// Notes: watches interface pins and the decode pulse
`timescale 1ns/1ps
module ddrpc_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ck,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [ddrpc_pkg::BA_W-1:0] ba,
  input wire logic [ddrpc_pkg::ROW_W-1:0] addr,
  input wire logic dqHOeN,
  input wire logic dqDOeN,
  input wire logic dqsHOeN,
  input wire logic dqsDOeN,
  input wire logic dqs,
  input wire logic dqsN,
  input wire logic dqsNHOeN,
  input wire logic dqsNDOeN,
  input wire logic cmdPulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence rdCmd;
    $rose(ck) && !csN && rasN && !casN && weN;
  endsequence
  sequence wrCmd;
    $rose(ck) && !csN && rasN && !casN && !weN;
  endsequence
  chk_ck_high_time: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
    else $error("link clock high time wrong");
  chk_pins_steady: assert property ($rose(ck) |-> $stable({csN, rasN, casN, weN, ba, addr}))
    else $error("command pins moved at clock rise");
  chk_rd_drive: assert property (rdCmd |-> ##[2:12] !dqDOeN)
    else $error("read not answered on data bus");
  chk_wr_quiet: assert property (wrCmd |-> dqDOeN [*8])
    else $error("device drove data during write");
  chk_wr_strobe: assert property (wrCmd |-> ##[1:12] !dqsHOeN)
    else $error("write strobe not driven");
  chk_dq_single: assert property (dqHOeN || dqDOeN)
    else $error("both ends drive data");
  chk_dqs_single: assert property (dqsHOeN || dqsDOeN)
    else $error("both ends drive strobe");
  chk_dqs_pair: assert property (!(dqsNHOeN && dqsNDOeN) |-> dqsN == !dqs)
    else $error("complementary strobe not inverse of strobe");
  chk_sel_pulse: assert property ($rose(ck) && !csN |-> ##[1:4] cmdPulse)
    else $error("selected command not decoded");
  chk_desel_mask: assert property ($rose(ck) && csN |-> ##1 !cmdPulse [*4])
    else $error("deselected clock decoded");
endmodule

// ==== tb/tb_ddr2_pin_command_decode.sv ====
// Purpose: both ends joined, driven over the register bus
// Assumes: clkEn held high, word transfers only
// Notes: command steps poll busy before judging the device
`timescale 1ns/1ps
module tb_ddr2_pin_command_decode;
  logic clk, reset_n, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] bankOpen;
  logic [13:0] actRow;
  ddrpc_pkg::ddrpc_cmd_t lastCmd;
  logic cmdPulse, termOn, rdqsOn, diffOn;
  int n_errors = 0;
  int checks_done = 0;
  ddrpc_if bus ();
  ddrpc_ctrl i_ddrpc_ctrl (.clk, .reset_n, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .pins(bus));
  ddrpc_device i_ddrpc_device (.clk, .reset_n, .clkEn(1'b1), .pins(bus), .bankOpen, .lastCmd,
    .cmdPulse, .termOn, .rdqsOn, .diffOn);
  ddrpc_props i_ddrpc_props (.clk, .reset_n, .ck(bus.ck), .csN(bus.csN), .rasN(bus.rasN),
    .casN(bus.casN), .weN(bus.weN), .ba(bus.ba), .addr(bus.addr), .dqHOeN(bus.dqHOeN),
    .dqDOeN(bus.dqDOeN), .dqsHOeN(bus.dqsHOeN), .dqsDOeN(bus.dqsDOeN), .dqs(bus.dqs), .dqsN(bus.dqsN),
    .dqsNHOeN(bus.dqsNHOeN), .dqsNDOeN(bus.dqsNDOeN), .cmdPulse);
  // row seen on the wire with each activate
  always @(posedge bus.ck) begin
    if (!bus.csN && !bus.rasN && bus.casN && bus.weN) begin
      actRow <= bus.addr;
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 500; n++) begin
      ahb(1'b0, ddrpc_pkg::REG_STAT, 32'h0);
      if (r[b] === v) break;
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic cmd(input ddrpc_pkg::ddrpc_cmd_t op, input logic [2:0] ba, input logic [13:0] a);
    ahb(1'b1, ddrpc_pkg::REG_CMD, {5'h00, op, 5'h00, ba, 2'h0, a});
    poll(0, 1'b0);
    settle();
  endtask
  task automatic t_regs();
    ahb(1'b0, ddrpc_pkg::REG_CTRL, 32'h0);
    check(r, 32'h6);
    ahb(1'b0, 8'h14, 32'h0);
    check(r, 32'h0);
    check({termOn, rdqsOn, diffOn}, 3'h1);
  endtask
  task automatic t_open();
    cmd(ddrpc_pkg::CMD_ACT, 3'h5, 14'h2001);
    check(bankOpen, 8'h20);
    check(actRow, 14'h2001);
    cmd(ddrpc_pkg::CMD_DESEL, 3'h2, 14'h0);
    check(bankOpen, 8'h20);
    check(lastCmd, ddrpc_pkg::CMD_ACT);
  endtask
  task automatic t_mode();
    ahb(1'b1, ddrpc_pkg::REG_CTRL, 32'h1);
    settle();
    check(termOn, 1'b0);
    cmd(ddrpc_pkg::CMD_MRS, 3'h1, 14'h0044);
    check(termOn, 1'b1);
    cmd(ddrpc_pkg::CMD_MRS, 3'h1, 14'h0C00);
    check({termOn, rdqsOn, diffOn}, 3'h2);
    ahb(1'b1, ddrpc_pkg::REG_CTRL, 32'h6);
    cmd(ddrpc_pkg::CMD_MRS, 3'h1, 14'h0004);
    check({termOn, rdqsOn, diffOn}, 3'h1);
  endtask
  task automatic t_data();
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, ddrpc_pkg::REG_WDATA, {23'h0, i == 5, 8'(8'h11 * (i + 1))});
    end
    ahb(1'b0, ddrpc_pkg::REG_STAT, 32'h0);
    check(r[3:2], 2'h1);
    cmd(ddrpc_pkg::CMD_WR, 3'h5, 14'h0000);
    cmd(ddrpc_pkg::CMD_WR, 3'h5, 14'h0400);
    check(bankOpen, 8'h00);
    ahb(1'b0, ddrpc_pkg::REG_STAT, 32'h0);
    check(r[3:2], 2'h2);
    cmd(ddrpc_pkg::CMD_ACT, 3'h5, 14'h2001);
    cmd(ddrpc_pkg::CMD_RD, 3'h5, 14'h0000);
    poll(1, 1'b1);
    ahb(1'b0, ddrpc_pkg::REG_RDATA, 32'h0);
    check(r, 32'h88772255);
    ahb(1'b0, ddrpc_pkg::REG_STAT, 32'h0);
    check(r[1], 1'b0);
  endtask
  task automatic t_pre();
    cmd(ddrpc_pkg::CMD_ACT, 3'h2, 14'h0000);
    cmd(ddrpc_pkg::CMD_PRE, 3'h5, 14'h0000);
    check(bankOpen, 8'h04);
    cmd(ddrpc_pkg::CMD_ACT, 3'h7, 14'h0010);
    cmd(ddrpc_pkg::CMD_PRE, 3'h0, 14'h0400);
    check(bankOpen, 8'h00);
    check(lastCmd, ddrpc_pkg::CMD_PRE);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_open();
    t_mode();
    t_data();
    t_pre();
    close_out();
  end
endmodule
